// ### verilog/setup_port_pkg.sv
// constants for the indexed chip setup and control port decoder
package setup_port_pkg;
  localparam logic [15:0] index_port_addr = 16'h0022;
  localparam logic [15:0] data_port_addr  = 16'h0023;
  localparam logic [7:0]  index_reset     = 8'h00;
  localparam logic [7:0]  reg_reset       = 8'h00;
  localparam logic [7:0]  reserved_value  = 8'hff;
  localparam logic [7:0]  mem_lo  = 8'h00;
  localparam logic [7:0]  mem_hi  = 8'h07;
  localparam logic [7:0]  cache_lo = 8'h10;
  localparam logic [7:0]  cache_hi = 8'h14;
  localparam logic [7:0]  pm_lo   = 8'h40;
  localparam logic [7:0]  pm_hi   = 8'h45;
  localparam logic [7:0]  mgmt_lo = 8'h90;
  localparam logic [7:0]  mgmt_hi = 8'h9d;
  localparam logic [7:0]  gpio_lo = 8'ha0;
  localparam logic [7:0]  gpio_hi = 8'hbd;
  localparam int          num_regs = 256;

  typedef enum logic [2:0] {
    grp_none  = 3'b000,
    grp_mem   = 3'b001,
    grp_cache = 3'b010,
    grp_pm    = 3'b011,
    grp_mgmt  = 3'b100,
    grp_gpio  = 3'b101
  } group_t;
endpackage

// ### verilog/indexed_config_port_decoder.sv
// index/data port front end for the chip setup register space
`timescale 1ns/1ns
module indexed_config_port_decoder (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // host i/o cycle, one-cycle request
  input  wire logic        io_req,
  input  wire logic        io_wr,
  input  wire logic [15:0] io_addr,
  input  wire logic [1:0]  io_be,
  input  wire logic [15:0] io_wdata,
  // answer
  output logic             io_ack,
  output logic [7:0]       io_rdata,
  output logic             io_hit,
  // debug echo to expansion bus
  input  wire logic        echo_en,
  output logic             echo_valid,
  output logic [7:0]       echo_index,
  output logic [7:0]       echo_data,
  output logic             echo_wr,
  // state visible to the chip
  output logic [7:0]       cur_index,
  output logic [2:0]       cur_group
);
  // register storage, flat over the index space
  logic [7:0] regs_q [setup_port_pkg::num_regs];
  logic [7:0] index_q, index_d;
  logic       ack_q, ack_d, hit_q, hit_d;
  logic [7:0] rdata_q, rdata_d;
  logic       ev_q, ev_d, ewr_q, ewr_d;
  logic [7:0] eidx_q, eidx_d, edat_q, edat_d;
  // group of the stored index, kept in a flop so cur_group leaves the block registered
  setup_port_pkg::group_t group_q, group_d;
  logic       wr_en;
  logic [7:0] wr_idx, wr_val;

  // group decode of an index
  function automatic setup_port_pkg::group_t decode(input logic [7:0] idx);
    if (idx <= setup_port_pkg::mem_hi) return setup_port_pkg::grp_mem;
    if (idx >= setup_port_pkg::cache_lo && idx <= setup_port_pkg::cache_hi)
      return setup_port_pkg::grp_cache;
    if (idx >= setup_port_pkg::pm_lo && idx <= setup_port_pkg::pm_hi)
      return setup_port_pkg::grp_pm;
    if (idx >= setup_port_pkg::mgmt_lo && idx <= setup_port_pkg::mgmt_hi)
      return setup_port_pkg::grp_mgmt;
    if (idx >= setup_port_pkg::gpio_lo && idx <= setup_port_pkg::gpio_hi)
      return setup_port_pkg::grp_gpio;
    return setup_port_pkg::grp_none;
  endfunction

  // next-state: index capture, data access, answer, echo
  always_comb begin
    logic idx_cyc, dat_cyc;
    idx_cyc = io_req && io_addr == setup_port_pkg::index_port_addr;
    dat_cyc = io_req && io_addr == setup_port_pkg::data_port_addr;
    index_d = index_q;
    wr_en   = 1'b0;
    wr_idx  = index_q;
    wr_val  = io_wdata[7:0];
    rdata_d = 8'h00;
    ack_d   = io_req;
    hit_d   = idx_cyc || dat_cyc;
    if (idx_cyc && io_wr && io_be[0]) begin
      index_d = io_wdata[7:0];
      if (io_be[1]) begin
        wr_en  = 1'b1;
        wr_idx = io_wdata[7:0];
        wr_val = io_wdata[15:8];
      end
    end else if (idx_cyc && !io_wr) begin
      rdata_d = index_q;
    end else if (dat_cyc && io_wr) begin
      wr_en = 1'b1;
    end else if (dat_cyc) begin
      if (decode(index_q) != setup_port_pkg::grp_none) rdata_d = regs_q[index_q];
      else rdata_d = setup_port_pkg::reserved_value;
    end
    if (decode(wr_idx) == setup_port_pkg::grp_none) wr_en = 1'b0;
    ev_d   = wr_en && echo_en;
    ewr_d  = 1'b1;
    eidx_d = wr_idx;
    edat_d = wr_val;
    if (dat_cyc && !io_wr && echo_en) begin
      ev_d   = 1'b1;
      ewr_d  = 1'b0;
      edat_d = rdata_d;
    end
    // decode the index that will be stored, so group and index move on the same edge
    group_d = decode(index_d);
  end

  // registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      index_q <= setup_port_pkg::index_reset;
      group_q <= decode(setup_port_pkg::index_reset);
      ack_q   <= 1'b0;
      hit_q   <= 1'b0;
      rdata_q <= 8'h00;
      ev_q    <= 1'b0;
      ewr_q   <= 1'b0;
      eidx_q  <= 8'h00;
      edat_q  <= 8'h00;
    end else begin
      index_q <= index_d;
      group_q <= group_d;
      ack_q   <= ack_d;
      hit_q   <= hit_d;
      rdata_q <= rdata_d;
      ev_q    <= ev_d;
      ewr_q   <= ewr_d;
      eidx_q  <= eidx_d;
      edat_q  <= edat_d;
    end
  end

  // storage array, one entry per index
  for (genvar i = 0; i < setup_port_pkg::num_regs; i++) begin : g_reg
    always_ff @(posedge clk) begin
      if (!rstn) regs_q[i] <= setup_port_pkg::reg_reset;
      else if (wr_en && wr_idx == 8'(i)) regs_q[i] <= wr_val;
    end
  end

  assign io_ack     = ack_q;
  assign io_rdata   = rdata_q;
  assign io_hit     = hit_q;
  assign echo_valid = ev_q;
  assign echo_index = eidx_q;
  assign echo_data  = edat_q;
  assign echo_wr    = ewr_q;
  assign cur_index  = index_q;
  assign cur_group  = group_q;

  property p_index_load;
    @(posedge clk) disable iff (!rstn)
    io_req && io_wr && io_be[0] && io_addr == setup_port_pkg::index_port_addr
      |=> cur_index == $past(io_wdata[7:0]);
  endproperty
  a_index_load: assert property (p_index_load) else $error("index not captured");

  property p_index_hold;
    @(posedge clk) disable iff (!rstn)
    !(io_req && io_wr && io_addr == setup_port_pkg::index_port_addr) |=> $stable(cur_index);
  endproperty
  a_index_hold: assert property (p_index_hold) else $error("index changed");

  property p_ack;
    @(posedge clk) disable iff (!rstn) io_req |=> io_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("no ack next cycle");

  property p_reserved_read;
    @(posedge clk) disable iff (!rstn)
    io_req && !io_wr && io_addr == setup_port_pkg::data_port_addr
      && decode(index_q) == setup_port_pkg::grp_none
      |=> io_rdata == setup_port_pkg::reserved_value;
  endproperty
  a_reserved_read: assert property (p_reserved_read) else $error("bad reserved read");

  // a data-port write to a decoded index lands in the entry that the index names
  property p_data_write;
    @(posedge clk) disable iff (!rstn)
    io_req && io_wr && io_addr == setup_port_pkg::data_port_addr
      && decode(index_q) != setup_port_pkg::grp_none
      |=> regs_q[cur_index] == $past(io_wdata[7:0]);
  endproperty
  a_data_write: assert property (p_data_write) else $error("data write lost");

  property p_word_write;
    @(posedge clk) disable iff (!rstn)
    io_req && io_wr && io_be == 2'b11 && io_addr == setup_port_pkg::index_port_addr
      && decode(io_wdata[7:0]) != setup_port_pkg::grp_none
      |=> regs_q[cur_index] == $past(io_wdata[15:8]);
  endproperty
  a_word_write: assert property (p_word_write) else $error("word write lost");

  property p_no_echo;
    @(posedge clk) disable iff (!rstn) !echo_en |=> !echo_valid;
  endproperty
  a_no_echo: assert property (p_no_echo) else $error("echo while disabled");

  property p_group_mem;
    @(posedge clk) disable iff (!rstn)
    cur_index <= setup_port_pkg::mem_hi |-> cur_group == setup_port_pkg::grp_mem;
  endproperty
  a_group_mem: assert property (p_group_mem) else $error("memory group decode");

  property p_group_cache;
    @(posedge clk) disable iff (!rstn)
    cur_index >= setup_port_pkg::cache_lo && cur_index <= setup_port_pkg::cache_hi
      |-> cur_group == setup_port_pkg::grp_cache;
  endproperty
  a_group_cache: assert property (p_group_cache) else $error("cache group decode");

  property p_group_mgmt;
    @(posedge clk) disable iff (!rstn)
    cur_index >= setup_port_pkg::mgmt_lo && cur_index <= setup_port_pkg::mgmt_hi
      |-> cur_group == setup_port_pkg::grp_mgmt;
  endproperty
  a_group_mgmt: assert property (p_group_mgmt) else $error("mgmt group decode");

  property p_group_gpio;
    @(posedge clk) disable iff (!rstn)
    cur_index >= setup_port_pkg::gpio_lo && cur_index <= setup_port_pkg::gpio_hi
      |-> cur_group == setup_port_pkg::grp_gpio;
  endproperty
  a_group_gpio: assert property (p_group_gpio) else $error("pin group decode");

  property p_group_pm;
    @(posedge clk) disable iff (!rstn)
    cur_index >= setup_port_pkg::pm_lo && cur_index <= setup_port_pkg::pm_hi
      |-> cur_group == setup_port_pkg::grp_pm;
  endproperty
  a_group_pm: assert property (p_group_pm) else $error("power group decode");

  // both ports are claimed on every cycle that reaches them
  property p_hit;
    @(posedge clk) disable iff (!rstn)
    io_req && (io_addr == setup_port_pkg::index_port_addr
      || io_addr == setup_port_pkg::data_port_addr) |=> io_hit;
  endproperty
  a_hit: assert property (p_hit) else $error("port access not claimed");

  // a write through a reserved index must leave storage untouched
  property p_reserved_write;
    @(posedge clk) disable iff (!rstn)
    io_req && io_wr && io_addr == setup_port_pkg::data_port_addr
      && decode(index_q) == setup_port_pkg::grp_none
      |=> regs_q[cur_index] == $past(regs_q[index_q]);
  endproperty
  a_reserved_write: assert property (p_reserved_write) else $error("reserved write");

  // with debug echo on, a landed data write is copied out on the next cycle
  property p_echo_write;
    @(posedge clk) disable iff (!rstn)
    echo_en && io_req && io_wr && io_addr == setup_port_pkg::data_port_addr
      && decode(index_q) != setup_port_pkg::grp_none
      |=> echo_valid && echo_wr && echo_data == $past(io_wdata[7:0]);
  endproperty
  a_echo_write: assert property (p_echo_write) else $error("write not echoed");
endmodule // indexed_config_port_decoder

// ### tb/host_io_model.sv
// host processor model issuing one-cycle i/o requests
`timescale 1ns/1ns
module host_io_model (
  // clock
  input  wire logic        clk,
  // i/o request
  output logic             req,
  output logic             wr,
  output logic [15:0]      addr,
  output logic [1:0]       be,
  output logic [15:0]      wdata
);
  // one request; released lines flip so stale values never pass for good ones
  task automatic xfer(input logic w, input logic [15:0] a, input logic [1:0] b,
                      input logic [15:0] d);
    @(posedge clk);
    req   <= 1'b1;
    wr    <= w;
    addr  <= a;
    be    <= b;
    wdata <= d;
    @(posedge clk);
    req   <= 1'b0;
    wr    <= ~w;
    addr  <= ~a;
    be    <= ~b;
    wdata <= ~d;
    // hand back between edges, while the one-cycle answer still stands
    @(negedge clk);
  endtask
  // idle bus at time zero
  initial begin
    req = 1'b0;
    wr = 1'b0;
    addr = 16'h0000;
    be = 2'h0;
    wdata = 16'h0000;
  end
endmodule // host_io_model

// ### tb/tb.sv
// self-checking bench for the indexed setup port decoder
`timescale 1ns/1ns
module tb;
  logic clk, rstn, echo_en, req, wr, ack, hit, ev, ew;
  logic [15:0] addr, wdata;
  logic [1:0]  be;
  logic [7:0]  rdata, ei, ed, ci, idx, v, want, mem [256];
  logic [2:0]  cg;
  logic [31:0] rs;
  int          n_errors, tests_run;
  logic [7:0]  corner [18] = '{8'h00, 8'h07, 8'h08, 8'h0f, 8'h10, 8'h14, 8'h15, 8'h3f,
    8'h40, 8'h45, 8'h46, 8'h90, 8'h9d, 8'h9e, 8'ha0, 8'hbd, 8'hbe, 8'hff};
  // device and host
  indexed_config_port_decoder u_dut (.clk(clk), .rstn(rstn), .io_req(req), .io_wr(wr),
    .io_addr(addr), .io_be(be), .io_wdata(wdata), .io_ack(ack), .io_rdata(rdata),
    .io_hit(hit), .echo_en(echo_en), .echo_valid(ev), .echo_index(ei), .echo_data(ed),
    .echo_wr(ew), .cur_index(ci), .cur_group(cg));
  host_io_model u_host (.clk(clk), .req(req), .wr(wr), .addr(addr), .be(be),
    .wdata(wdata));
  // expected group of an index
  function automatic logic [2:0] grp(input logic [7:0] i);
    if (i <= 8'h07) return 3'h1;
    if (i >= 8'h10 && i <= 8'h14) return 3'h2;
    if (i >= 8'h40 && i <= 8'h45) return 3'h3;
    if (i >= 8'h90 && i <= 8'h9d) return 3'h4;
    if (i >= 8'ha0 && i <= 8'hbd) return 3'h5;
    return 3'h0;
  endfunction
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one access, answered on the next edge
  task automatic io(input logic w, input logic [15:0] a, input logic [1:0] b,
                    input logic [15:0] d);
    u_host.xfer(w, a, b, d);
    chk(8'(ack), 8'h01);
  endtask
  task automatic give_verdict;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    give_verdict();
  end
  // main sequence
  initial begin
    rstn = 1'b0;
    echo_en = 1'b0;
    rs = 32'hca01;
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    chk(ci, 8'h00);
    for (int n = 0; n < 48; n++) begin
      rs = xs(rs);
      idx = (n < 18) ? corner[n] : rs[7:0];
      v = rs[15:8];
      @(posedge clk);
      echo_en <= rs[16];
      if (n % 3 == 0) begin
        io(1'b1, 16'h0022, 2'b11, {v, idx});
      end else begin
        io(1'b1, 16'h0022, 2'b01, {~v, idx});
        io(1'b0, 16'h0080, 2'b01, 16'h0000);
        chk(8'(hit), 8'h00);
        io(1'b1, 16'h0023, 2'b01, {~v, v});
      end
      if (grp(idx) != 3'h0) mem[idx] = v;
      chk(ci, idx);
      chk(8'(cg), 8'(grp(idx)));
      io(1'b0, 16'h0022, 2'b01, 16'h0000);
      chk(rdata, idx);
      chk(8'(hit), 8'h01);
      io(1'b0, 16'h0023, 2'b01, 16'h0000);
      want = (grp(idx) != 3'h0) ? mem[idx] : 8'hff;
      chk(rdata, want);
      chk(8'(ev), 8'(echo_en));
      if (echo_en) begin
        chk(ed, want);
        chk(ei, idx);
        chk(8'(ew), 8'h00);
      end
    end
    // reset in mid-run clears the index, its group and the stored register at index 0
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    chk(ci, 8'h00);
    chk(8'(cg), 8'(grp(8'h00)));
    io(1'b0, 16'h0023, 2'b01, 16'h0000);
    chk(rdata, 8'h00);
    // read-modify-write that keeps every other bit of the entry
    io(1'b1, 16'h0023, 2'b01, 16'h005a);
    io(1'b0, 16'h0023, 2'b01, 16'h0000);
    io(1'b1, 16'h0023, 2'b01, {8'h00, rdata | 8'h80});
    io(1'b0, 16'h0023, 2'b01, 16'h0000);
    chk(rdata, 8'hda);
    give_verdict();
  end
endmodule // tb
